// ===== rtl/afe_cfg_pkg.sv
// shared constants and types of the front-end configuration register bank
package afe_cfg_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 6;
    localparam int CNT_W = 5;
    // serial frame: three address bits then sixteen data bits
    localparam logic [4:0] ADDR_BITS = 5'h03;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] READ_LAST = 5'h0F;
    // register offsets
    localparam logic [2:0] OFS_POWER_DOWN = 3'h0;
    localparam logic [2:0] OFS_RX_FILTER_TEST = 3'h1;
    localparam logic [2:0] OFS_PREDRIVER_TUNE = 3'h2;
    localparam logic [2:0] OFS_RESERVED_FOUR = 3'h3;
    localparam logic [2:0] OFS_GAIN_OFFSET = 3'h4;
    localparam logic [2:0] OFS_TX_FILTER = 3'h5;
    // reset values
    localparam logic [15:0] RST_POWER_DOWN = 16'h0002;
    localparam logic [15:0] RST_RX_FILTER_TEST = 16'h0008;
    localparam logic [15:0] RST_PREDRIVER_TUNE = 16'h7800;
    localparam logic [15:0] RST_RESERVED_FOUR = 16'h7ACE;
    localparam logic [15:0] RST_GAIN_OFFSET = 16'h0000;
    localparam logic [15:0] RST_TX_FILTER = 16'hC800;
    // field positions
    localparam int POS_RX_OFF = 0;
    localparam int POS_TX_OFF = 1;
    localparam int POS_DAC_OFF = 2;
    localparam int POS_CHIP_OFF = 3;
    localparam int POS_BLOCK_LO = 4;
    localparam int POS_LPF_BYPASS = 15;
    localparam int POS_GAIN_LO = 2;
    localparam int POS_TUNE_CONT = 11;
    localparam int POS_AGC_MANUAL = 13;
    localparam int POS_TX_LPF_BYPASS = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_DONE = 2'h3,
        ST_READ = 2'h2
    } port_state_t;

    typedef struct packed {
        logic rx_off_during_tx_mode;
        logic tx_off_during_rx_mode;
        logic converter_off_during_rx_mode;
        logic chip_power_down;
        logic [11:0] block_power_down;
        logic lowpass_filter_bypass;
        logic [14:0] test_bus_select;
        logic [2:0] predriver_gain_code;
        logic tune_continuous;
        logic tune_active;
        logic agc_manual;
        logic tx_lowpass_filter_bypass;
    } ctl_out_t;

    function automatic logic [15:0] reg_default(input logic [2:0] idx);
        case (idx)
            OFS_POWER_DOWN: reg_default = RST_POWER_DOWN;
            OFS_RX_FILTER_TEST: reg_default = RST_RX_FILTER_TEST;
            OFS_PREDRIVER_TUNE: reg_default = RST_PREDRIVER_TUNE;
            OFS_RESERVED_FOUR: reg_default = RST_RESERVED_FOUR;
            OFS_GAIN_OFFSET: reg_default = RST_GAIN_OFFSET;
            OFS_TX_FILTER: reg_default = RST_TX_FILTER;
            default: reg_default = 16'h0000;
        endcase
    endfunction
endpackage

// ===== rtl/pin_sync.sv
// two-flop synchronisers for pin inputs plus edge detection
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pins and synchronised view
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_level,
    output logic [W-1:0] pin_rise,
    output logic [W-1:0] pin_fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    if (W < 1) begin : g_bad_width
        $error("pin_sync needs at least one bit");
    end

    // the first stage feeds only the second, edges come from later stages
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
            prev_ff <= RST_VAL;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edges are one-cycle pulses, two cycles after the pin moves
    assign pin_level = sync_ff;
    assign pin_rise = sync_ff & ~prev_ff;
    assign pin_fall = ~sync_ff & prev_ff;
endmodule

// ===== rtl/afe_config_register_bank.sv
// configuration register bank behind the three-wire serial port
`timescale 1ns/1ps
// Behaviour
// - three-bit address, MSB first, selects six registers
// - first register bit0 powers receiver down in transmit while the shutdown pin is high
// - bit1 powers transmitter down in receive
// - bit2 powers converter down in receive
// - bit3 powers whole chip down
// - bits 4-15 held, drive block power-downs
// - second register bit15 bypasses receive filter
// - third register bits 4:2 pick predriver gain
// - third register bit11 makes tuning continuous
// - fifth register bit13 selects manual gain control
// - write shifts data LSB first after the address, extra clock commits
module afe_config_register_bank #(
    parameter int NREGS = afe_cfg_pkg::NUM_REGS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial configuration port
    input wire logic sclk_pin,
    input wire logic serial_write_select,
    input wire logic serial_port_data_in,
    output logic serial_port_data_out,
    output logic serial_port_data_oe,
    // device control pins
    input wire logic reset_input_low,
    input wire logic receiver_shutdown_input,
    input wire logic tx_active,
    // decoded controls to the analog blocks
    output afe_cfg_pkg::ctl_out_t ctl
);
    import afe_cfg_pkg::*;

    localparam logic [2:0] LAST_ADDR = 3'(NREGS - 1);

    logic [5:0] pin_level;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic sclk_fall;
    logic swr_rise;
    logic swr_fall;
    logic sdi_s;
    logic in_reset;
    logic shutdown_s;
    logic tx_s;

    port_state_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0] hold_addr_ff, nxt_hold_addr;
    logic [DATA_W-1:0] hold_data_ff, nxt_hold_data;
    logic [ADDR_W-1:0] last_addr_ff, nxt_last_addr;
    logic [DATA_W-1:0] out_shift_ff, nxt_out_shift;
    logic oe_ff, nxt_oe;
    logic [DATA_W-1:0] regs_ff [NREGS];
    logic [DATA_W-1:0] nxt_regs [NREGS];
    ctl_out_t ctl_ff, nxt_ctl;

    if (NREGS < 1 || NREGS > 8) begin : g_bad_regs
        $error("register count must fit a three-bit address");
    end

    // pin order: sclk, write select, data, reset low, shutdown, tx
    // sclk idles high, so its stages reset high and no false edge follows
    pin_sync #(
        .W(6),
        .RST_VAL(6'h24)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_raw({sclk_pin, serial_write_select, serial_port_data_in,
                  reset_input_low, receiver_shutdown_input, tx_active}),
        .pin_level(pin_level),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    assign sclk_fall = pin_fall[5];
    assign swr_rise = pin_rise[4];
    assign swr_fall = pin_fall[4];
    assign sdi_s = pin_level[3];
    assign in_reset = rst | ~pin_level[2];
    assign shutdown_s = pin_level[1];
    assign tx_s = pin_level[0];

    // serial port sequencer and register storage
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_hold_addr = hold_addr_ff;
        nxt_hold_data = hold_data_ff;
        nxt_last_addr = last_addr_ff;
        nxt_out_shift = out_shift_ff;
        nxt_oe = oe_ff;
        nxt_regs = regs_ff;
        if (in_reset) begin
            for (int i = 0; i < NREGS; i++) begin
                nxt_regs[i] = reg_default(3'(i));
            end
            nxt_st = ST_IDLE;
            nxt_cnt = '0;
            nxt_hold_addr = '0;
            nxt_hold_data = '0;
            nxt_last_addr = '0;
            nxt_out_shift = '0;
            nxt_oe = 1'b0;
        end else if (swr_rise) begin
            nxt_st = ST_SHIFT;
            nxt_cnt = '0;
            nxt_oe = 1'b0;
        end else if (swr_fall) begin
            // reading returns the register written last
            nxt_st = ST_READ;
            nxt_cnt = '0;
            // unmapped codes have no storage and read back as zero
            if (last_addr_ff <= LAST_ADDR) begin
                nxt_out_shift = regs_ff[last_addr_ff];
            end else begin
                nxt_out_shift = '0;
            end
            nxt_oe = 1'b1;
        end else if (sclk_fall) begin
            case (st_ff)
                ST_SHIFT: begin
                    if (cnt_ff < ADDR_BITS) begin
                        // address arrives MSB first
                        nxt_hold_addr = {hold_addr_ff[1:0], sdi_s};
                        nxt_cnt = cnt_ff + 5'h01;
                    end else if (cnt_ff < FRAME_LAST) begin
                        // data arrives LSB first
                        nxt_hold_data = {sdi_s, hold_data_ff[15:1]};
                        nxt_cnt = cnt_ff + 5'h01;
                    end else begin
                        // the extra clock commits the holding buffer
                        if (hold_addr_ff <= LAST_ADDR) begin
                            nxt_regs[hold_addr_ff] = hold_data_ff;
                        end
                        nxt_last_addr = hold_addr_ff;
                        nxt_st = ST_DONE;
                    end
                end
                ST_READ: begin
                    if (cnt_ff < READ_LAST) begin
                        nxt_out_shift = {1'b0, out_shift_ff[15:1]};
                        nxt_cnt = cnt_ff + 5'h01;
                    end else begin
                        // release the data pin after the sixteenth bit
                        nxt_oe = 1'b0;
                        nxt_st = ST_IDLE;
                    end
                end
                default: begin
                    nxt_st = st_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
        cnt_ff <= nxt_cnt;
        hold_addr_ff <= nxt_hold_addr;
        hold_data_ff <= nxt_hold_data;
        last_addr_ff <= nxt_last_addr;
        out_shift_ff <= nxt_out_shift;
        oe_ff <= nxt_oe;
        regs_ff <= nxt_regs;
    end

    // lsb leaves first; the pin only changes on a detected falling edge
    assign serial_port_data_out = out_shift_ff[0];
    assign serial_port_data_oe = oe_ff;

    // decoded controls, registered so the analog side sees clean levels
    always_comb begin
        nxt_ctl.rx_off_during_tx_mode = regs_ff[0][POS_RX_OFF] & shutdown_s
            & tx_s;
        nxt_ctl.tx_off_during_rx_mode = regs_ff[0][POS_TX_OFF]
            & ~tx_s;
        nxt_ctl.converter_off_during_rx_mode = regs_ff[0][POS_DAC_OFF]
            & ~tx_s;
        nxt_ctl.chip_power_down = regs_ff[0][POS_CHIP_OFF];
        nxt_ctl.block_power_down = regs_ff[0][15:POS_BLOCK_LO];
        nxt_ctl.lowpass_filter_bypass =
            regs_ff[1][POS_LPF_BYPASS];
        // test bus bits pass through; software keeps them at default
        nxt_ctl.test_bus_select = regs_ff[1][14:0];
        nxt_ctl.predriver_gain_code = regs_ff[2][4:POS_GAIN_LO];
        nxt_ctl.tune_continuous = regs_ff[2][POS_TUNE_CONT];
        nxt_ctl.tune_active = regs_ff[2][POS_TUNE_CONT]
            | in_reset;
        nxt_ctl.agc_manual = regs_ff[4][POS_AGC_MANUAL];
        nxt_ctl.tx_lowpass_filter_bypass = regs_ff[5][POS_TX_LPF_BYPASS];
    end

    always_ff @(posedge clk) begin
        ctl_ff <= nxt_ctl;
    end

    assign ctl = ctl_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_commit_addr: assert property (
        (!in_reset && !swr_rise && !swr_fall && sclk_fall && st_ff == ST_SHIFT
         && cnt_ff == FRAME_LAST && hold_addr_ff <= LAST_ADDR)
        |=> regs_ff[$past(hold_addr_ff)] == $past(hold_data_ff)
            && st_ff == ST_DONE)
        else $error("commit did not store the holding buffer");
    a_rx_off_gate: assert property (
        (!regs_ff[0][POS_RX_OFF] || !shutdown_s)
        |=> !ctl.rx_off_during_tx_mode)
        else $error("receiver powered down without enable and shutdown");
    a_tx_off_rx: assert property (
        (regs_ff[0][POS_TX_OFF] && !tx_s) |=> ctl.tx_off_during_rx_mode)
        else $error("transmitter not powered down in receive");
    a_dac_off_rx: assert property (
        tx_s |=> !ctl.converter_off_during_rx_mode)
        else $error("converter powered down while transmitting");
    a_chip_off: assert property (
        ##1 ctl.chip_power_down == $past(regs_ff[0][POS_CHIP_OFF]))
        else $error("chip power down does not follow its bit");
    a_block_hold: assert property (
        ##1 ctl.block_power_down == $past(regs_ff[0][15:4]))
        else $error("block power downs do not follow stored bits");
    a_lpf_bypass: assert property (
        $rose(regs_ff[1][POS_LPF_BYPASS]) |=> ctl.lowpass_filter_bypass)
        else $error("receive filter bypass not applied");
    a_gain_code: assert property (
        ##1 ctl.predriver_gain_code == $past(regs_ff[2][4:2]))
        else $error("predriver gain code mismatch");
    a_tune_mode: assert property (
        (!regs_ff[2][POS_TUNE_CONT] && !in_reset) |=> !ctl.tune_active)
        else $error("tuning active outside reset in one-shot mode");
    a_agc_manual: assert property (
        ##1 ctl.agc_manual == $past(regs_ff[4][POS_AGC_MANUAL]))
        else $error("manual gain control does not follow its bit");
    a_reset_defaults: assert property (
        in_reset |=> regs_ff[0] == RST_POWER_DOWN
            && regs_ff[2] == RST_PREDRIVER_TUNE
            && regs_ff[3] == RST_RESERVED_FOUR && st_ff == ST_IDLE)
        else $error("registers not at defaults after reset");
    a_read_shift: assert property (
        (!in_reset && !swr_rise && !swr_fall && sclk_fall && st_ff == ST_READ
         && cnt_ff < READ_LAST)
        |=> serial_port_data_out == $past(out_shift_ff[1]) && oe_ff)
        else $error("read data not shifted lsb first");
    a_read_end: assert property (
        (!in_reset && !swr_rise && !swr_fall && sclk_fall && st_ff == ST_READ
         && cnt_ff == READ_LAST) |=> !oe_ff && st_ff == ST_IDLE)
        else $error("data pin not released after sixteen bits");

    c_commit: cover property (st_ff == ST_SHIFT ##1 st_ff == ST_DONE);
    c_read_done: cover property (st_ff == ST_READ ##1 st_ff == ST_IDLE);
    c_pin_reset: cover property (!pin_level[2] && !rst);
endmodule

// ===== dv/afe_ctl_model.sv
// serial configuration controller model for the three-wire port
`timescale 1ns/1ps
module afe_ctl_model (
    // device clock, used only to keep pin moves off its rising edge
    input wire logic clk,
    // serial port pins
    output logic sclk,
    output logic sel,
    output logic sdrv,
    input wire logic sline
);
    // sclk idles high between frames, so each bit costs one fall
    initial begin
        sclk = 1'h1;
        sel = 1'h0;
        sdrv = 1'h0;
    end
    // data set up while sclk is high, held well past the fall
    task automatic clk_bit(input logic b);
        sdrv = b;
        #31.25 sclk = 1'h0;
        #62.5 sclk = 1'h1;
        #31.25;
    endtask
    // address msb first, data lsb first, one commit clock
    task automatic write_reg(input logic [2:0] a, input logic [15:0] d,
                             input int nfall);
        logic [18:0] bits;
        bits = {d, a[0], a[1], a[2]};
        // start 1 ns past a falling clk edge; bits then alternate phases
        @(negedge clk);
        #1 sel = 1'h1;
        #100;
        for (int i = 0; i < nfall; i++) begin
            clk_bit(i < 19 ? bits[i] : ~sdrv);
        end
        #100;
    endtask
    // abort path: select falls without a commit clock
    task automatic drop_sel();
        sel = 1'h0;
        #200;
    endtask
    // read only right after a write; bit0 sampled before the first fall, the rest on rising sclk
    task automatic read_reg(output logic [15:0] q);
        @(negedge clk);
        sel = 1'h0;
        sdrv = ~sdrv; // released line must not hold the last bit
        #100 q[0] = sline;
        for (int i = 1; i < 17; i++) begin
            #31.25 sclk = 1'h0;
            #62.5 sclk = 1'h1;
            if (i < 16) q[i] = sline;
            #31.25;
        end
    endtask
endmodule

// ===== dv/afe_config_register_bank_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module afe_config_register_bank_tb_top;
    import afe_cfg_pkg::*;
    logic clk, rst, reset_input_low, receiver_shutdown_input, tx_active;
    logic sclk, sel, sdrv, sline, dout, doe;
    logic [15:0] q;
    logic [2:0] pd_exp;
    logic [2:0] pd_got;
    ctl_out_t ctl;
    int fails = 0;
    int samples_checked = 0;
    // decoded outputs expected with all defaults and tx idle
    localparam ctl_out_t DEF = {1'h0, 1'h1, 1'h0, 1'h0, 12'h000, 1'h0,
        15'h0008, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0};
    // device drive wins the shared data line while enabled
    assign sline = doe ? dout : sdrv;
    // the three mode-gated power-down outputs, as one word
    assign pd_got = {ctl.rx_off_during_tx_mode, ctl.tx_off_during_rx_mode,
                     ctl.converter_off_during_rx_mode};
    afe_config_register_bank i_dut (
        .clk(clk), .rst(rst), .sclk_pin(sclk),
        .serial_write_select(sel), .serial_port_data_in(sline),
        .serial_port_data_out(dout), .serial_port_data_oe(doe),
        .reset_input_low(reset_input_low),
        .receiver_shutdown_input(receiver_shutdown_input),
        .tx_active(tx_active), .ctl(ctl)
    );
    afe_ctl_model i_ctl (
        .clk(clk), .sclk(sclk), .sel(sel), .sdrv(sdrv), .sline(sline)
    );
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // full frame then read-back of the same register
    task automatic wr_rd(input logic [2:0] a, input logic [15:0] d,
                         input logic [15:0] exp);
        i_ctl.write_reg(a, d, 20);
        i_ctl.read_reg(q);
        `CHK("readback", exp, q)
        `CHK("oe_idle", 1'h0, doe)
    endtask
    // hang guard well beyond the whole sequence
    initial begin
        #500000;
        fails++;
        finish_test();
    end
    initial begin
        rst = 1'h1;
        reset_input_low = 1'h1;
        receiver_shutdown_input = 1'h0;
        tx_active = 1'h0;
        wait_clk(6);
        rst = 1'h0;
        wait_clk(4);
        `CHK("defaults", DEF, ctl)
        // every register, plus the decoded outputs it feeds
        wr_rd(OFS_POWER_DOWN, 16'hA5A8, 16'hA5A8);
        `CHK("chip_off", 1'h1, ctl.chip_power_down)
        `CHK("blocks", 12'hA5A, ctl.block_power_down)
        `CHK("tx_off", 1'h0, ctl.tx_off_during_rx_mode)
        wr_rd(OFS_RX_FILTER_TEST, 16'h8000, 16'h8000);
        `CHK("lpf_byp", 1'h1, ctl.lowpass_filter_bypass)
        wr_rd(OFS_PREDRIVER_TUNE, 16'h7000, 16'h7000);
        `CHK("tune_cont", 1'h0, ctl.tune_continuous)
        `CHK("tune_act", 1'h0, ctl.tune_active)
        wr_rd(OFS_RESERVED_FOUR, 16'h1234, 16'h1234);
        wr_rd(OFS_GAIN_OFFSET, 16'h2000, 16'h2000);
        `CHK("agc_man", 1'h1, ctl.agc_manual)
        wr_rd(OFS_TX_FILTER, 16'h0010, 16'h0010);
        `CHK("tx_lpf", 1'h1, ctl.tx_lowpass_filter_bypass)
        // unmapped code stores nothing and reads back zero
        wr_rd(3'h6, 16'hFFFF, 16'h0000);
        `CHK("unmapped", 1'h1, ctl.agc_manual)
        // all eight gain codes
        for (int g = 0; g < 8; g++) begin
            wr_rd(OFS_PREDRIVER_TUNE, 16'(g) << 2, 16'(g) << 2);
            `CHK("gain", 3'(g), ctl.predriver_gain_code)
        end
        // power-down decode against every shutdown and tx pin pair
        wr_rd(OFS_POWER_DOWN, 16'h0007, 16'h0007);
        for (int m = 0; m < 4; m++) begin
            {receiver_shutdown_input, tx_active} = 2'(m);
            // rx off needs shutdown and tx; tx and converter off need rx
            pd_exp = {m == 3, !m[0], !m[0]};
            wait_clk(8);
            `CHK("pd_mode", pd_exp, pd_got)
        end
        // select dropped mid-frame leaves the register untouched
        receiver_shutdown_input = 1'h0;
        tx_active = 1'h0;
        i_ctl.write_reg(OFS_POWER_DOWN, 16'h0008, 10);
        i_ctl.drop_sel();
        wait_clk(8);
        `CHK("abort", 1'h0, ctl.chip_power_down)
        // reset pin restores defaults while low and after release
        wr_rd(OFS_PREDRIVER_TUNE, 16'h0000, 16'h0000);
        wait_clk(1);
        reset_input_low = 1'h0;
        wait_clk(6);
        `CHK("pin_rst", DEF, ctl)
        reset_input_low = 1'h1;
        wait_clk(6);
        `CHK("after_rst", DEF, ctl)
        finish_test();
    end
endmodule
